// ==== logic/node_id_pkg.sv ====
// Package of offsets, reset values and field positions for the node identity register slice
package node_id_pkg;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_IDENT_UPPER  = 8'h24;
    localparam logic [7:0] OFS_IDENT_LOWER  = 8'h28;
    localparam logic [7:0] OFS_ROM_MAP      = 8'h34;
    localparam logic [7:0] OFS_FAIL_LOW     = 8'h38;
    localparam logic [7:0] OFS_FAIL_HIGH    = 8'h3c;
    localparam logic [7:0] OFS_MAKER        = 8'h40;
    localparam logic [7:0] OFS_ID_CTRL      = 8'h44;

    // ************************************************************
    // Reset values and constants
    // ************************************************************
    localparam logic [31:0] IDENT_RESET     = 32'h0000_0000;
    localparam logic [31:0] ROM_MAP_RESET   = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000;
    // Arbitrary neutral maker value
    localparam logic [31:0] MAKER_CODE_VAL  = 32'h00a5_5a00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int ROM_BASE_LSB   = 10;
    localparam int ROM_WIN_BITS   = 10;
    localparam int REQ_BUS_LSB    = 22;
    localparam int REQ_NODE_LSB   = 16;
    localparam int OFS_HI_WIDTH   = 16;
    localparam int CTRL_LOCK_BIT  = 0;
    localparam int CTRL_EEP_BIT   = 1;

    // Identifier load sequencing states
    typedef enum logic [1:0] {
        ID_EMPTY,
        ID_HALF,
        ID_LOCKED
    } ident_state_t;

endpackage : node_id_pkg

// ==== logic/rom_addr_map.sv ====
// Configuration ROM quadlet read address former
`timescale 1ns/100ps
module rom_addr_map
(
    input  wire logic        clk_sys,          // System clock
    input  wire logic        reset_n,          // Async reset, active low
    input  wire logic [31:0] rom_base_reg,     // Mapping register value
    input  wire logic        rom_rd_req,       // Quadlet read request pulse
    input  wire logic [47:0] rom_rd_offset,    // 1394 request offset
    output logic             rom_host_valid,   // Host address valid pulse
    output logic [31:0]      rom_host_addr     // Formed host address
);
    import node_id_pkg::*;

    // ************************************************************
    // Address forming
    // ************************************************************
    logic [31:0] next_addr;

    // RULE7 add low offset bits
    always_comb
    begin
        next_addr = rom_base_reg + {22'h000000, rom_rd_offset[ROM_WIN_BITS-1:0]};
    end

    // Register the result and the request marker
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rom_host_valid <= 1'b0;
            rom_host_addr  <= 32'h0000_0000;
        end
        else
        begin
            rom_host_valid <= rom_rd_req;
            if (rom_rd_req)
            begin
                rom_host_addr <= next_addr;
            end
        end
    end

endmodule : rom_addr_map

// ==== logic/node_id_regs.sv ====
// Node identity, ROM mapping, failed posted-write and maker code registers
// Contract
// RULE1: upper identifier register holds upper 32 bits
// RULE2: identifiers clear to zero on hardware reset
// RULE3: EEPROM loads identifiers, then locks them
// RULE4: firmware loads once when no EEPROM
// RULE5: only global hardware reset clears identifiers
// RULE6: lower identifier holds low 32 bits
// RULE7: host address is base plus offset bits
// RULE8: ROM base bits 31-10, low bits zero
// RULE9: failure updates both error registers
// RULE10: low error register takes low offset
// RULE11: requester bus and node in high half
// RULE12: upper offset bits in low half
// RULE13: error registers need no reset value
// RULE14: fixed read-only maker code register
// RULE15: error registers hold until next failure
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module node_id_regs
(
    input  wire logic        clk_sys,          // System clock, 250 MHz
    input  wire logic        reset_n,          // Global hardware reset, active low
    input  wire logic        soft_reset,       // Software reset pulse
    input  wire logic [7:0]  reg_addr,         // Register byte address
    input  wire logic [31:0] reg_wdata,        // Register write data
    input  wire logic        reg_wr,           // Write strobe
    input  wire logic        reg_rd,           // Read strobe
    output logic [31:0]      reg_rdata,        // Read data, one cycle later
    input  wire logic        eeprom_present,   // EEPROM detected pin
    input  wire logic        eeprom_load,      // EEPROM identifier load pulse
    input  wire logic [63:0] eeprom_ident,     // Identifier from EEPROM
    input  wire logic        pw_fail,          // Posted write failure pulse
    input  wire logic [47:0] pw_fail_offset,   // Failed write destination offset
    input  wire logic [15:0] pw_fail_source,   // Failed write requester
    input  wire logic        rom_rd_req,       // Config ROM quadlet read pulse
    input  wire logic [47:0] rom_rd_offset,    // Config ROM read offset
    output logic             rom_host_valid,   // Host address valid pulse
    output logic [31:0]      rom_host_addr,    // Host memory address
    output logic             ident_locked      // Identifier frozen
);
    import node_id_pkg::*;

    // ************************************************************
    // Storage
    // ************************************************************
    logic [31:0]  node_ident_upper;
    logic [31:0]  node_ident_lower;
    logic [31:0]  rom_image_base_map;
    logic [31:0]  failed_write_offset_low;
    logic [31:0]  failed_write_offset_high;
    ident_state_t ident_state;
    logic [2:0]   eep_sync;
    logic         eep_seen;
    logic         eep_stable;
    logic         wr_upper;
    logic         wr_lower;
    logic [31:0]  next_rdata;

    // ************************************************************
    // EEPROM detect pin synchroniser
    // ************************************************************
    // Three stages, value accepted when stages two and three agree
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            eep_sync <= 3'h0;
            eep_seen <= 1'b0;
        end
        else
        begin
            eep_sync <= {eep_sync[1:0], eeprom_present};
            if (eep_sync[1] == eep_sync[2])
            begin
                eep_seen <= eep_sync[2];
            end
        end
    end

    assign eep_stable = eep_seen;

    // ************************************************************
    // Identifier load and lock
    // ************************************************************
    assign wr_upper = reg_wr && (reg_addr == OFS_IDENT_UPPER) && !eep_stable;
    assign wr_lower = reg_wr && (reg_addr == OFS_IDENT_LOWER) && !eep_stable;

    // RULE5 soft reset ignored here
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // RULE2 clear to zero
            node_ident_upper <= IDENT_RESET;
            node_ident_lower <= IDENT_RESET;
            ident_state      <= ID_EMPTY;
        end
        else
        begin
            unique case (ident_state)
                ID_EMPTY:
                begin
                    // RULE3 EEPROM load locks
                    if (eep_stable && eeprom_load)
                    begin
                        node_ident_upper <= eeprom_ident[63:32];
                        node_ident_lower <= eeprom_ident[31:0];
                        ident_state      <= ID_LOCKED;
                    end
                    // RULE4 firmware single load
                    else if (wr_upper || wr_lower)
                    begin
                        if (wr_upper)
                        begin
                            // RULE1 upper quadlet
                            node_ident_upper <= reg_wdata;
                        end
                        if (wr_lower)
                        begin
                            // RULE6 lower quadlet
                            node_ident_lower <= reg_wdata;
                        end
                        ident_state <= ID_HALF;
                    end
                end
                ID_HALF:
                begin
                    // RULE4 second quadlet then lock
                    if (wr_upper)
                    begin
                        node_ident_upper <= reg_wdata;
                        ident_state      <= ID_LOCKED;
                    end
                    else if (wr_lower)
                    begin
                        node_ident_lower <= reg_wdata;
                        ident_state      <= ID_LOCKED;
                    end
                end
                ID_LOCKED:
                begin
                    ident_state <= ID_LOCKED;
                end
                // Unused code falls back to the frozen state, never to a writable one
                default:
                begin
                    ident_state <= ID_LOCKED;
                end
            endcase
        end
    end

    // Lock indicator output
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ident_locked <= 1'b0;
        end
        else
        begin
            ident_locked <= (ident_state == ID_LOCKED);
        end
    end

    // ************************************************************
    // Configuration ROM mapping register
    // ************************************************************
    // RULE8 base kept in upper bits only
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rom_image_base_map <= ROM_MAP_RESET;
        end
        else if (soft_reset)
        begin
            rom_image_base_map <= ROM_MAP_RESET;
        end
        else if (reg_wr && (reg_addr == OFS_ROM_MAP))
        begin
            rom_image_base_map <= {reg_wdata[31:ROM_BASE_LSB], 10'h000};
        end
    end

    // RULE7 host address former
    rom_addr_map u_rom_addr_map
    (
        .clk_sys        (clk_sys),
        .reset_n        (reset_n),
        .rom_base_reg   (rom_image_base_map),
        .rom_rd_req     (rom_rd_req),
        .rom_rd_offset  (rom_rd_offset),
        .rom_host_valid (rom_host_valid),
        .rom_host_addr  (rom_host_addr)
    );

    // ************************************************************
    // Posted write error capture
    // ************************************************************
    // RULE13 no reset; RULE9 capture on failure; RULE15 hold otherwise
    always_ff @(posedge clk_sys)
    begin
        if (pw_fail)
        begin
            // RULE10 low offset
            failed_write_offset_low <= pw_fail_offset[31:0];
            // RULE11 requester; RULE12 upper offset
            failed_write_offset_high <= {pw_fail_source,
                                         pw_fail_offset[47:32]};
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb
    begin
        next_rdata = READ_ZERO;
        unique case (reg_addr)
            OFS_IDENT_UPPER: next_rdata = node_ident_upper;
            OFS_IDENT_LOWER: next_rdata = node_ident_lower;
            OFS_ROM_MAP:     next_rdata = rom_image_base_map;
            OFS_FAIL_LOW:    next_rdata = failed_write_offset_low;
            OFS_FAIL_HIGH:   next_rdata = failed_write_offset_high;
            // RULE14 fixed maker code
            OFS_MAKER:       next_rdata = MAKER_CODE_VAL;
            OFS_ID_CTRL:
            begin
                next_rdata[CTRL_LOCK_BIT] = (ident_state == ID_LOCKED);
                next_rdata[CTRL_EEP_BIT]  = eep_stable;
            end
            default:         next_rdata = READ_ZERO;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= READ_ZERO;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= READ_ZERO;
        end
    end

endmodule : node_id_regs

// ==== dv/node_id_checker_assertions.sv ====
// Port checker for the node identity register slice
`timescale 1ns/100ps
module node_id_checker
(
    input wire logic        clk_sys,        // Clock
    input wire logic        reset_n,        // Reset
    input wire logic        soft_reset,     // Soft reset
    input wire logic [7:0]  reg_addr,       // Address
    input wire logic [31:0] reg_wdata,      // Write data
    input wire logic        reg_wr,         // Write
    input wire logic        reg_rd,         // Read
    input wire logic [31:0] reg_rdata,      // Read data
    input wire logic        pw_fail,        // Failure
    input wire logic [47:0] pw_fail_offset, // Failed offset
    input wire logic [15:0] pw_fail_source, // Requester
    input wire logic        rom_rd_req,     // ROM read
    input wire logic [47:0] rom_rd_offset,  // ROM offset
    input wire logic        rom_host_valid, // Address valid
    input wire logic [31:0] rom_host_addr,  // Host address
    input wire logic        ident_locked    // Frozen
);
    import node_id_pkg::*;
    logic [31:0]       base_shd;
    logic [63:0]       fail_shd;
    logic              fail_seen;
    wire  logic [31:0] fail_lo = fail_shd[31:0];
    wire  logic [31:0] fail_hi = fail_shd[63:32];
    wire  logic [31:0] rom_lo  = {22'h0, rom_rd_offset[9:0]};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Shadow of the mapping register, cleared by either reset
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            base_shd <= ROM_MAP_RESET;
        else if (soft_reset)
            base_shd <= ROM_MAP_RESET;
        else if (reg_wr && reg_addr == OFS_ROM_MAP)
            base_shd <= {reg_wdata[31:10], 10'h000};
    end

    // Marks that a failure has been captured
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            fail_seen <= 1'b0;
        else if (pw_fail)
            fail_seen <= 1'b1;
    end

    // Copy of the last failure, needs no reset value
    always_ff @(posedge clk_sys)
    begin
        if (pw_fail)
            fail_shd <= {pw_fail_source, pw_fail_offset};
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence rd_of(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence

    maker_code_a: assert property (rd_of(OFS_MAKER) |=> reg_rdata == MAKER_CODE_VAL)
        else $error("Maker code read wrong");
    rom_map_read_a: assert property (rd_of(OFS_ROM_MAP) |=>
        reg_rdata == $past(base_shd)) else $error("Mapping register read wrong");
    rom_pulse_a: assert property (1'b1 |=> rom_host_valid == $past(rom_rd_req))
        else $error("Host address valid pulse wrong");
    rom_addr_a: assert property (rom_rd_req |=>
        rom_host_addr == $past(base_shd) + $past(rom_lo)) else $error("Host address wrong");
    rom_addr_hold_a: assert property (!rom_rd_req |=> $stable(rom_host_addr))
        else $error("Host address moved without request");
    fail_low_a: assert property (fail_seen ##0 rd_of(OFS_FAIL_LOW) |=>
        reg_rdata == $past(fail_lo)) else $error("Failed offset low wrong");
    fail_high_a: assert property (fail_seen ##0 rd_of(OFS_FAIL_HIGH) |=>
        reg_rdata == $past(fail_hi)) else $error("Failed requester or offset high wrong");
    lock_hold_a: assert property (ident_locked |=> ident_locked)
        else $error("Identifier lock dropped");
    ident_clear_a: assert property ($rose(reset_n) |-> !ident_locked ##1 !ident_locked)
        else $error("Identifier locked right after reset");
endmodule : node_id_checker

bind node_id_regs node_id_checker u_chk
(
    .clk_sys, .reset_n, .soft_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pw_fail, .pw_fail_offset, .pw_fail_source, .rom_rd_req,
    .rom_rd_offset, .rom_host_valid, .rom_host_addr, .ident_locked
);

// ==== dv/far_side_model.sv ====
// Model of the EEPROM, the link receive path and the failing requester
`timescale 1ns/100ps
module far_side_model
(
    input  wire logic   clk_sys,        // System clock
    output logic        eeprom_present, // EEPROM detected
    output logic        eeprom_load,    // Identifier load pulse
    output logic [63:0] eeprom_ident,   // Identifier image
    output logic        pw_fail,        // Failure pulse
    output logic [47:0] pw_fail_offset, // Failed offset
    output logic [15:0] pw_fail_source, // Failed requester
    output logic        rom_rd_req,     // ROM quadlet read pulse
    output logic [47:0] rom_rd_offset   // ROM read offset
);
    // Idle levels at time zero
    initial
    begin
        eeprom_present = 1'b0;
        eeprom_load    = 1'b0;
        eeprom_ident   = 64'h0;
        pw_fail        = 1'b0;
        pw_fail_offset = 48'h0;
        pw_fail_source = 16'h0;
        rom_rd_req     = 1'b0;
        rom_rd_offset  = 48'h0;
    end

    task automatic eep_load(input logic [63:0] id);
        @(posedge clk_sys);
        eeprom_load  <= 1'b1;
        eeprom_ident <= id;
        @(posedge clk_sys);
        eeprom_load  <= 1'b0;
        eeprom_ident <= ~id;
    endtask : eep_load

    // posted write fails at its destination
    task automatic fail_write(input logic [47:0] off, input logic [15:0] src);
        @(posedge clk_sys);
        pw_fail        <= 1'b1;
        pw_fail_offset <= off;
        pw_fail_source <= src;
        @(posedge clk_sys);
        pw_fail        <= 1'b0;
        pw_fail_offset <= ~off;
        pw_fail_source <= ~src;
    endtask : fail_write

    // only offsets inside the ROM window are passed on
    task automatic rom_rd(input logic [9:0] lo);
        @(posedge clk_sys);
        rom_rd_req    <= 1'b1;
        rom_rd_offset <= 48'hffff_f000_0400 + {38'h0, lo};
        @(posedge clk_sys);
        rom_rd_req    <= 1'b0;
        rom_rd_offset <= ~rom_rd_offset;
    endtask : rom_rd

    // EEPROM detect pin level, changed on a rising edge
    task automatic set_present(input logic v);
        @(posedge clk_sys);
        eeprom_present <= v;
    endtask : set_present
endmodule : far_side_model

// ==== dv/test_node_id_regs.sv ====
// Self-checking bench for the node identity register slice
`timescale 1ns/100ps
module test_node_id_regs;
    import node_id_pkg::*;
    logic        clk_sys, reset_n, soft_reset, reg_wr, reg_rd, ident_locked;
    logic        eeprom_present, eeprom_load, pw_fail, rom_rd_req, rom_host_valid;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rom_host_addr;
    logic [63:0] eeprom_ident;
    logic [47:0] pw_fail_offset, rom_rd_offset;
    logic [15:0] pw_fail_source;
    logic [9:0]  lo_tab [3] = '{10'h000, 10'h155, 10'h3ff};
    int          miscompares = 0;
    int          cmp_count   = 0;

    node_id_regs u_dut
    (
        .clk_sys, .reset_n, .soft_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .eeprom_present, .eeprom_load, .eeprom_ident, .pw_fail,
        .pw_fail_offset, .pw_fail_source, .rom_rd_req, .rom_rd_offset,
        .rom_host_valid, .rom_host_addr, .ident_locked
    );
    far_side_model u_far
    (
        .clk_sys, .eeprom_present, .eeprom_load, .eeprom_ident, .pw_fail,
        .pw_fail_offset, .pw_fail_source, .rom_rd_req, .rom_rd_offset
    );

    // Clock at 4 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask : rd

    task automatic hw_reset();
        reset_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
    endtask : hw_reset

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    // Watchdog against a hung run
    initial
    begin
        #40000;
        miscompares++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        reset_n    = 1'b0;
        soft_reset = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        hw_reset();
        rd(OFS_IDENT_UPPER, IDENT_RESET);
        rd(OFS_IDENT_LOWER, IDENT_RESET);
        rd(OFS_ROM_MAP, ROM_MAP_RESET);
        wr(OFS_MAKER, 32'hffff_ffff);
        rd(OFS_MAKER, MAKER_CODE_VAL);
        rd(8'h10, READ_ZERO);
        wr(OFS_ROM_MAP, 32'hffff_ffff);
        rd(OFS_ROM_MAP, 32'hffff_fc00);
        for (int i = 0; i < 3; i++)
        begin
            u_far.rom_rd(lo_tab[i]);
            #1 chk("rom_host_valid", 32'h1, {31'h0, rom_host_valid});
            chk("rom_host_addr", 32'hffff_fc00 + lo_tab[i], rom_host_addr);
        end
        @(posedge clk_sys);
        #1 chk("rom_host_valid", 32'h0, {31'h0, rom_host_valid});
        u_far.eep_load(64'h1111_2222_3333_4444);
        wr(OFS_IDENT_UPPER, 32'h1357_9bdf);
        #1 chk("ident_locked", 32'h0, {31'h0, ident_locked});
        wr(OFS_IDENT_LOWER, 32'h2468_ace0);
        rd(OFS_IDENT_UPPER, 32'h1357_9bdf);
        rd(OFS_IDENT_LOWER, 32'h2468_ace0);
        rd(OFS_ID_CTRL, 32'h0000_0001);
        wr(OFS_IDENT_UPPER, 32'h0);
        rd(OFS_IDENT_UPPER, 32'h1357_9bdf);
        @(posedge clk_sys) soft_reset <= 1'b1;
        @(posedge clk_sys) soft_reset <= 1'b0;
        rd(OFS_IDENT_LOWER, 32'h2468_ace0);
        chk("ident_locked", 32'h1, {31'h0, ident_locked});
        rd(OFS_ROM_MAP, ROM_MAP_RESET);
        u_far.fail_write(48'h1234_89ab_cdef, {10'h2a5, 6'h1b});
        rd(OFS_FAIL_LOW, 32'h89ab_cdef);
        rd(OFS_FAIL_HIGH, {10'h2a5, 6'h1b, 16'h1234});
        rd(OFS_FAIL_HIGH, {10'h2a5, 6'h1b, 16'h1234});
        u_far.fail_write(48'hfedc_0000_0001, 16'hffff);
        rd(OFS_FAIL_LOW, 32'h0000_0001);
        rd(OFS_FAIL_HIGH, 32'hffff_fedc);
        u_far.set_present(1'b1);
        hw_reset();
        repeat (6) @(posedge clk_sys);
        rd(OFS_IDENT_UPPER, IDENT_RESET);
        rd(OFS_ID_CTRL, 32'h0000_0002);
        wr(OFS_IDENT_UPPER, 32'h5555_5555);
        rd(OFS_IDENT_UPPER, IDENT_RESET);
        u_far.eep_load(64'hcafe_0001_8765_4321);
        rd(OFS_IDENT_UPPER, 32'hcafe_0001);
        wr(OFS_IDENT_LOWER, 32'h0);
        rd(OFS_IDENT_LOWER, 32'h8765_4321);
        rd(OFS_ID_CTRL, 32'h0000_0003);
        chk("ident_locked", 32'h1, {31'h0, ident_locked});
        print_verdict();
    end
endmodule : test_node_id_regs
